//--- shared/pmc_defs.svh
// register offsets, field positions, reset values and counts
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_ADDR_W       4
`define PMC_OFF_MODE     4'h0
`define PMC_OFF_WDOG     4'h4
`define PMC_OFF_STATUS   4'h8
`define PMC_OFF_PAWAKE   4'hc
`define PMC_B_HIGH_LOW_CLOCK_SELECT      0
`define PMC_B_IDLE       1
`define PMC_B_HTO        2
`define PMC_B_LTO        3
`define PMC_B_FAST_WAKEUP_ENABLE      4
`define PMC_B_CKS_LO     5
`define PMC_B_SYSKEEP    7
`define PMC_B_PDF        0
`define PMC_B_TO         1
`define PMC_B_ST_LO      4
`define PMC_RST_MODE     8'h01
`define PMC_RST_WDOG     8'h7a
`define PMC_RST_PAWAKE   8'h00
`define PMC_WDOG_OFF     4'ha
`define PMC_CKS_SLOW_MAX 3'h1
`define PMC_HXT_WAKE_CYC 1024
`define PMC_LOW_SPEED_INTERNAL_OSC_RDY_CYC 2
`endif

//--- shared/pmc_pkg.sv
// types of the power-mode controller
package pmc_pkg;
  typedef enum logic [3:0] {
    PMC_NORMAL   = 4'h0,
    PMC_TO_SLOW  = 4'h1,
    PMC_SLOW     = 4'h3,
    PMC_TO_FAST  = 4'h2,
    PMC_DEEP     = 4'h6,
    PMC_LIGHT    = 4'h7,
    PMC_IDLE_SYSCLK_OFF_MODE    = 4'h5,
    PMC_IDLE_SYSCLK_ON_MODE    = 4'h4,
    PMC_FASTWAKE = 4'hc,
    PMC_WAKEWAIT = 4'hd
  } pmc_state_e;
  typedef struct packed {
    logic sys;
    logic sys_low;
    logic time_base;
    logic sub;
    logic hosc;
    logic wdt_run;
  } pmc_clk_s;
  typedef struct packed {
    logic wdt_clear;
    logic full_reset;
    logic pc_sp_reset;
    logic wake;
    logic irq_service;
    logic resume_next;
  } pmc_evt_s;
endpackage : pmc_pkg

//--- core/pmc_power_mode_controller.sv
// power-mode controller: clock switching, halt modes and wake-up
// Summary of operation
// - slow mode runs on the low oscillator; switch completes only once it is ready.
// - back to the high clock only after its ready flag is set.
// - halt with idle select 0, watchdog and detector off enters deep sleep.
// - deep sleep stops system, watchdog and time-base clocks; watchdog cleared, stopped.
// - halt with idle select 0 and watchdog or detector on enters light sleep.
// - light sleep stops system and time base; sub-clocked watchdog cleared, keeps counting.
// - halt with idle select 1 and clock keep 0 enters first idle mode.
// - first idle stops system clock; sub-clocked watchdog runs, system-clocked one stops.
// - halt with idle select 1 and clock keep 1 keeps all clocks running.
// - second idle clears an enabled watchdog, which keeps counting on either source.
// - entering any halt mode sets power-down flag and clears timeout flag.
// - wake on external reset, enabled port A falling edge, interrupt or overflow.
// - external-reset wake gives full reset; overflow wake resets program counter and stack.
// - power-down flag cleared by power-up or watchdog clear, set by halt.
// - timeout while halted sets timeout flag, resets only program counter and stack.
// - port A pins enabled per bit; such a wake resumes after halt.
// - disabled or stack-full interrupt wake resumes after halt; else normal response.
// - an interrupt already pending at halt is no wake source.
// - light-sleep wake with crystal and fast wake runs first from low oscillator.
// - peripherals on the system clock follow it to the low source.
// - switching to the low clock turns the high clock off.
// - fast wake runs on sub clock for 1024 crystal cycles, then sets ready.
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_power_mode_controller #(
  parameter int PA_W         = 8,                  // port A width
  parameter int IRQ_W        = 8,                  // interrupt sources
  parameter int HXT_WAKE_CYC = `PMC_HXT_WAKE_CYC   // crystal settle count
) (
  input  wire logic                   clk_i,          // 25 MHz clock
  input  wire logic                   rst_n_i,        // power-up reset
  input  wire logic [`PMC_ADDR_W-1:0] addr_i,         // register address
  input  wire logic [7:0]             wdata_i,        // write data
  input  wire logic                   we_i,           // write strobe
  input  wire logic                   re_i,           // read strobe
  output      logic [7:0]             rdata_o,        // read data
  input  wire logic                   halt_i,         // halt executed
  input  wire logic                   clr_wdt_i,      // watchdog clear done
  input  wire logic                   ext_reset_i,    // external reset pin
  input  wire logic                   wdt_ovf_i,      // watchdog overflow
  input  wire logic                   wdt_cfg_en_i,   // watchdog option on
  input  wire logic                   wdt_src_sub_i,  // watchdog on sub clock
  input  wire logic                   lvd_en_i,       // detector on
  input  wire logic                   hxt_sel_i,      // crystal is system osc
  input  wire logic [PA_W-1:0]        port_a_i,       // port A pins
  input  wire logic [IRQ_W-1:0]       irq_req_i,      // request flags
  input  wire logic [IRQ_W-1:0]       irq_en_i,       // interrupt enables
  input  wire logic                   stack_full_i,   // stack full
  output      pmc_pkg::pmc_clk_s      clk_en_o,       // clock gates
  output      pmc_pkg::pmc_evt_s      evt_o,          // event pulses
  output      pmc_pkg::pmc_state_e    state_o         // present mode
);
  generate
    if (HXT_WAKE_CYC < 1 || HXT_WAKE_CYC > 65535 || PA_W < 1 || PA_W > 8
        || IRQ_W < 1) begin : g_chk
      $error("pmc: unsupported parameter value");
    end
  endgenerate

  pmc_pkg::pmc_state_e state;
  pmc_pkg::pmc_state_e next_state;
  logic [7:0]          mode_reg;
  logic [7:0]          wdog_reg;
  logic [7:0]          pawake_reg;
  logic                power_down_flag;
  logic                tof;
  logic [15:0]         hcnt;
  logic [1:0]          lcnt;
  logic [PA_W-1:0]     pa_q;
  logic [IRQ_W-1:0]    irq_snap;
  logic                high_osc_ready_flag;
  logic                low_osc_ready_flag;
  logic                want_low;
  logic                wdt_en;
  logic                running;
  logic                halted;
  logic                pa_wake;
  logic [IRQ_W-1:0]    irq_new;
  logic                irq_wake;
  logic                wake;
  pmc_pkg::pmc_clk_s   ck;

  assign want_low = !mode_reg[`PMC_B_HIGH_LOW_CLOCK_SELECT]
                    && (mode_reg[`PMC_B_CKS_LO+:3] <= `PMC_CKS_SLOW_MAX);
  assign wdt_en   = wdt_cfg_en_i || (wdog_reg[3:0] != `PMC_WDOG_OFF);
  assign running  = (state == pmc_pkg::PMC_NORMAL) || (state == pmc_pkg::PMC_SLOW)
                    || (state == pmc_pkg::PMC_TO_SLOW) || (state == pmc_pkg::PMC_TO_FAST);
  assign halted   = (state == pmc_pkg::PMC_DEEP) || (state == pmc_pkg::PMC_LIGHT)
                    || (state == pmc_pkg::PMC_IDLE_SYSCLK_OFF_MODE) || (state == pmc_pkg::PMC_IDLE_SYSCLK_ON_MODE);
  assign high_osc_ready_flag      = (hcnt == 16'(HXT_WAKE_CYC));
  assign low_osc_ready_flag      = (lcnt == 2'(`PMC_LOW_SPEED_INTERNAL_OSC_RDY_CYC));
  assign pa_wake  = |(pa_q & ~port_a_i & pawake_reg[PA_W-1:0]);
  assign irq_new  = irq_req_i & ~irq_snap;
  assign irq_wake = |irq_new;
  assign wake     = ext_reset_i || pa_wake || irq_wake || (wdt_ovf_i && ck.wdt_run);

  // clock gates decoded from the mode
  always_comb begin
    ck = '0;
    case (state)
      pmc_pkg::PMC_NORMAL, pmc_pkg::PMC_TO_SLOW: begin
        ck.sys       = 1'b1;
        ck.time_base = 1'b1;
        ck.hosc      = 1'b1;
        ck.sub       = (state == pmc_pkg::PMC_TO_SLOW) || (wdt_en && wdt_src_sub_i);
        ck.wdt_run   = wdt_en;
      end
      pmc_pkg::PMC_SLOW, pmc_pkg::PMC_TO_FAST: begin
        ck.sys       = 1'b1;
        ck.sys_low   = 1'b1;
        ck.time_base = 1'b1;
        ck.sub       = 1'b1;
        ck.hosc      = (state == pmc_pkg::PMC_TO_FAST);
        ck.wdt_run   = wdt_en;
      end
      pmc_pkg::PMC_DEEP: ck = '0;
      pmc_pkg::PMC_LIGHT: begin
        ck.sub     = 1'b1;
        ck.wdt_run = wdt_en && wdt_src_sub_i;
      end
      pmc_pkg::PMC_IDLE_SYSCLK_OFF_MODE: begin
        ck.time_base = 1'b1;
        ck.sub       = 1'b1;
        ck.wdt_run   = wdt_en && wdt_src_sub_i;
      end
      pmc_pkg::PMC_IDLE_SYSCLK_ON_MODE: begin
        ck.sys       = 1'b1;
        ck.sys_low   = want_low;
        ck.time_base = 1'b1;
        ck.sub       = 1'b1;
        ck.hosc      = !want_low;
        ck.wdt_run   = wdt_en;
      end
      pmc_pkg::PMC_FASTWAKE: begin
        ck.sys       = 1'b1;
        ck.sys_low   = 1'b1;
        ck.time_base = 1'b1;
        ck.sub       = 1'b1;
        ck.hosc      = 1'b1;
        ck.wdt_run   = wdt_en;
      end
      pmc_pkg::PMC_WAKEWAIT: begin
        ck.sub     = 1'b1;
        ck.hosc    = !want_low;
        ck.wdt_run = wdt_en && wdt_src_sub_i;
      end
      default: ck = '0;
    endcase
  end
  assign clk_en_o = ck;
  assign state_o  = state;

  // mode sequencing
  always_comb begin
    next_state = state;
    case (state)
      pmc_pkg::PMC_NORMAL:  if (want_low) next_state = pmc_pkg::PMC_TO_SLOW;
      pmc_pkg::PMC_TO_SLOW: if (low_osc_ready_flag) next_state = pmc_pkg::PMC_SLOW;
      pmc_pkg::PMC_SLOW:    if (!want_low) next_state = pmc_pkg::PMC_TO_FAST;
      pmc_pkg::PMC_TO_FAST: if (high_osc_ready_flag) next_state = pmc_pkg::PMC_NORMAL;
      pmc_pkg::PMC_DEEP, pmc_pkg::PMC_LIGHT, pmc_pkg::PMC_IDLE_SYSCLK_OFF_MODE: begin
        if (wake) begin
          if (state == pmc_pkg::PMC_LIGHT && mode_reg[`PMC_B_FAST_WAKEUP_ENABLE] && hxt_sel_i
              && !want_low) begin
            next_state = pmc_pkg::PMC_FASTWAKE;
          end else begin
            next_state = pmc_pkg::PMC_WAKEWAIT;
          end
        end
      end
      pmc_pkg::PMC_IDLE_SYSCLK_ON_MODE:
        if (wake) next_state = want_low ? pmc_pkg::PMC_SLOW : pmc_pkg::PMC_NORMAL;
      pmc_pkg::PMC_FASTWAKE: if (high_osc_ready_flag) next_state = pmc_pkg::PMC_NORMAL;
      pmc_pkg::PMC_WAKEWAIT: begin
        if (want_low && low_osc_ready_flag) next_state = pmc_pkg::PMC_SLOW;
        else if (!want_low && high_osc_ready_flag) next_state = pmc_pkg::PMC_NORMAL;
      end
      default: next_state = pmc_pkg::PMC_NORMAL;
    endcase
    if (running && halt_i) begin
      if (mode_reg[`PMC_B_IDLE]) begin
        next_state = wdog_reg[`PMC_B_SYSKEEP] ? pmc_pkg::PMC_IDLE_SYSCLK_ON_MODE
                                              : pmc_pkg::PMC_IDLE_SYSCLK_OFF_MODE;
      end else begin
        next_state = (wdt_en || lvd_en_i) ? pmc_pkg::PMC_LIGHT
                                          : pmc_pkg::PMC_DEEP;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) state <= pmc_pkg::PMC_NORMAL;
    else          state <= next_state;
  end

  // oscillator settle counters
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !ck.hosc) hcnt <= 16'h0;
    else if (!high_osc_ready_flag)            hcnt <= hcnt + 16'h1;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !ck.sub) lcnt <= 2'h0;
    else if (!low_osc_ready_flag)           lcnt <= lcnt + 2'h1;
  end

  // wake-source history
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pa_q     <= '0;
      irq_snap <= '0;
    end else begin
      pa_q <= port_a_i;
      if (running && halt_i) irq_snap <= irq_req_i;
      else if (!halted)      irq_snap <= '0;
      else                   irq_snap <= irq_snap & irq_req_i;
    end
  end

  // power-down and timeout flags, set wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      power_down_flag <= 1'b0;
      tof <= 1'b0;
    end else begin
      if (running && halt_i)  power_down_flag <= 1'b1;
      else if (clr_wdt_i)     power_down_flag <= 1'b0;
      if (halted && wdt_ovf_i && ck.wdt_run) tof <= 1'b1;
      else if (running && halt_i)            tof <= 1'b0;
    end
  end

  // event pulses
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      evt_o <= '0;
    end else begin
      evt_o.wdt_clear   <= running && halt_i;
      evt_o.wake        <= halted && wake;
      evt_o.full_reset  <= halted && ext_reset_i;
      evt_o.pc_sp_reset <= halted && !ext_reset_i && wdt_ovf_i && ck.wdt_run;
      evt_o.irq_service <= halted && !ext_reset_i && irq_wake
                           && |(irq_new & irq_en_i) && !stack_full_i;
      evt_o.resume_next <= halted && !ext_reset_i && !(wdt_ovf_i && ck.wdt_run)
                           && (pa_wake || (irq_wake
                           && !(|(irq_new & irq_en_i) && !stack_full_i)));
    end
  end

  // register file
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mode_reg   <= `PMC_RST_MODE;
      wdog_reg   <= `PMC_RST_WDOG;
      pawake_reg <= `PMC_RST_PAWAKE;
    end else if (we_i) begin
      case (addr_i)
        `PMC_OFF_MODE:   mode_reg   <= wdata_i;
        `PMC_OFF_WDOG:   wdog_reg   <= wdata_i;
        `PMC_OFF_PAWAKE: pawake_reg <= wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (re_i) begin
      case (addr_i)
        `PMC_OFF_MODE: begin
          rdata_o              <= mode_reg;
          rdata_o[`PMC_B_HTO] <= high_osc_ready_flag;
          rdata_o[`PMC_B_LTO] <= low_osc_ready_flag;
        end
        `PMC_OFF_WDOG:   rdata_o <= wdog_reg;
        `PMC_OFF_STATUS: rdata_o <= {state, 2'h0, tof, power_down_flag};
        `PMC_OFF_PAWAKE: rdata_o <= pawake_reg;
        default:         rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // cycles spent in fast wake, bounds the sub-clock span
  logic [16:0] fw_cnt;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || state != pmc_pkg::PMC_FASTWAKE) fw_cnt <= 17'h0;
    else                                             fw_cnt <= fw_cnt + 17'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence halt_run_s;
    running && halt_i;
  endsequence
  sequence fast_wake_s;
    state == pmc_pkg::PMC_LIGHT && wake && mode_reg[`PMC_B_FAST_WAKEUP_ENABLE] && hxt_sel_i && !want_low;
  endsequence

  halt_flags_a: assert property (halt_run_s |=> power_down_flag && !tof)
    else $error("halt did not set power-down and clear timeout");
  deep_entry_a: assert property (halt_run_s ##0 (!mode_reg[`PMC_B_IDLE] && !wdt_en
    && !lvd_en_i) |=> state == pmc_pkg::PMC_DEEP)
    else $error("deep sleep not entered");
  deep_clocks_a: assert property (state == pmc_pkg::PMC_DEEP
    |-> !ck.sys && !ck.time_base && !ck.wdt_run && !ck.sub)
    else $error("clock running in deep sleep");
  light_entry_a: assert property (halt_run_s ##0 (!mode_reg[`PMC_B_IDLE]
    && (wdt_en || lvd_en_i)) |=> state == pmc_pkg::PMC_LIGHT && ck.sub && !ck.sys)
    else $error("light sleep not entered");
  idle_entry_a: assert property (halt_run_s ##0 mode_reg[`PMC_B_IDLE]
    |=> (ck.sys == $past(wdog_reg[`PMC_B_SYSKEEP])) && ck.time_base)
    else $error("idle mode clocks wrong");
  slow_wait_a: assert property ($rose(state == pmc_pkg::PMC_TO_SLOW)
    |-> (!ck.sys_low && ck.hosc)[*3] ##1 state == pmc_pkg::PMC_SLOW)
    else $error("slow switch did not wait for low oscillator");
  slow_hosc_a: assert property (state == pmc_pkg::PMC_SLOW |-> !ck.hosc)
    else $error("high clock left on in slow mode");
  fast_ready_a: assert property (state == pmc_pkg::PMC_NORMAL && $past(state)
    != pmc_pkg::PMC_NORMAL && $past(state) != pmc_pkg::PMC_IDLE_SYSCLK_ON_MODE |-> $past(high_osc_ready_flag))
    else $error("full speed before high oscillator ready");
  fast_wake_a: assert property (fast_wake_s |=> ck.sys && ck.sys_low && !high_osc_ready_flag)
    else $error("fast wake sequence wrong");
  fast_span_a: assert property (state == pmc_pkg::PMC_FASTWAKE
    |-> fw_cnt <= 17'(HXT_WAKE_CYC))
    else $error("fast wake outlasted crystal settle count");
  fast_exit_a: assert property (state == pmc_pkg::PMC_FASTWAKE && high_osc_ready_flag
    |=> state == pmc_pkg::PMC_NORMAL)
    else $error("fast wake did not end on ready");
  timeout_a: assert property (halted && wdt_ovf_i && ck.wdt_run && !ext_reset_i
    |=> tof && evt_o.pc_sp_reset && !evt_o.full_reset)
    else $error("timeout wake wrong");
  stale_irq_a: assert property (halted && !ext_reset_i && !pa_wake && !wdt_ovf_i
    && ((irq_req_i & ~irq_snap) == '0) |=> halted)
    else $error("woken without a new source");
  pa_wake_a: assert property (halted && pa_wake && !ext_reset_i && !wdt_ovf_i
    |=> !halted && evt_o.resume_next)
    else $error("port A wake lost");
endmodule : pmc_power_mode_controller

//--- tb/pmc_core_model.sv
// processor-core model: register cycles, halt and watchdog clear
`timescale 1ns/1ps
`include "pmc_defs.svh"
module pmc_core_model (
  input  wire logic       clk_i,   // system clock
  input  wire logic [7:0] rdata_i, // read data
  output      logic [3:0] addr_o,  // register address
  output      logic [7:0] wdata_o, // write data
  output      logic       we_o,    // write strobe
  output      logic       re_o,    // read strobe
  output      logic       halt_o,  // halt executed
  output      logic       clr_o    // watchdog clear done
);
  initial begin
    {addr_o, wdata_o, we_o, re_o, halt_o, clr_o} = '0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {we_o, addr_o, wdata_o} <= {1'b1, a, d};
    @(posedge clk_i);
    {we_o, addr_o, wdata_o} <= {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    {re_o, addr_o} <= {1'b1, a};
    @(posedge clk_i);
    {re_o, addr_o} <= {1'b0, ~a};
    #1 d = rdata_i;
  endtask : rd
  task automatic halt;
    @(posedge clk_i);
    halt_o <= 1'b1;
    @(posedge clk_i);
    halt_o <= 1'b0;
  endtask : halt
  task automatic clear;
    @(posedge clk_i);
    clr_o <= 1'b1;
    @(posedge clk_i);
    clr_o <= 1'b0;
  endtask : clear
  task automatic go_slow(input logic c0);
    wr(`PMC_OFF_MODE, {2'b00, c0, 5'h00});
  endtask : go_slow
  // back to full speed, then poll the high clock ready bit
  task automatic go_fast(input logic [2:0] k, output bit ok);
    logic [7:0] d;
    wr(`PMC_OFF_MODE, (k < 3'h2) ? 8'h01 : {k, 5'h00});
    ok = 1'b0;
    for (int n = 0; n < 100 && !ok; n++) begin
      rd(`PMC_OFF_MODE, d);
      ok = (d[`PMC_B_HTO] === 1'b1);
    end
  endtask : go_fast
endmodule : pmc_core_model

//--- tb/testbench.sv
// self-checking bench for the power-mode controller
`timescale 1ns/1ps
`include "pmc_defs.svh"
module testbench;
  localparam int HW = 8;
  logic                clk_i, rst_n_i, ext_reset_i, wdt_ovf_i, stack_full_i, wdt_cfg_en;
  logic                wdt_src_sub_i, lvd_en_i, hxt_sel_i, we, re, halt, clr;
  logic [3:0]          addr;
  logic [7:0]          wdata, rdata, port_a_i, irq_req_i, irq_en_i;
  pmc_pkg::pmc_clk_s   clk_en;
  pmc_pkg::pmc_evt_s   evt;
  pmc_pkg::pmc_state_e st;
  logic [5:0]          seen;
  logic [31:0]         rnd;
  int                  fail_count, checks;

  pmc_core_model core (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .we_o(we), .re_o(re), .halt_o(halt), .clr_o(clr));
  pmc_power_mode_controller #(.HXT_WAKE_CYC(HW)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .halt_i(halt),
    .clr_wdt_i(clr), .ext_reset_i(ext_reset_i), .wdt_ovf_i(wdt_ovf_i),
    .wdt_cfg_en_i(wdt_cfg_en),
    .wdt_src_sub_i(wdt_src_sub_i), .lvd_en_i(lvd_en_i), .hxt_sel_i(hxt_sel_i),
    .port_a_i(port_a_i), .irq_req_i(irq_req_i), .irq_en_i(irq_en_i),
    .stack_full_i(stack_full_i), .clk_en_o(clk_en), .evt_o(evt), .state_o(st));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [3:0] exp_mode(logic idle, logic keep, logic wdt, logic low_voltage_detector);
    if (idle) return keep ? pmc_pkg::PMC_IDLE_SYSCLK_ON_MODE : pmc_pkg::PMC_IDLE_SYSCLK_OFF_MODE;
    return (wdt | low_voltage_detector) ? pmc_pkg::PMC_LIGHT : pmc_pkg::PMC_DEEP;
  endfunction : exp_mode
  // {sys, time_base, sub, wdt_run}
  function automatic logic [3:0] exp_clk(logic [3:0] m, logic wdt, logic sub);
    case (m)
      pmc_pkg::PMC_DEEP:  return 4'b0000;
      pmc_pkg::PMC_LIGHT: return {3'b001, wdt & sub};
      pmc_pkg::PMC_IDLE_SYSCLK_OFF_MODE: return {3'b011, wdt & sub};
      default:            return {3'b111, wdt};
    endcase
  endfunction : exp_clk
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic step;
    @(posedge clk_i);
    #1 seen = seen | evt;
  endtask : step
  task automatic wait_st(input logic [3:0] s, output int n);
    n = 0;
    while (st !== s && n < 100) begin
      step();
      n++;
    end
  endtask : wait_st
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  initial begin
    #(40 * 50000);
    fail_count++;
    end_sim();
  end

  initial begin
    logic [7:0] d, mk;
    logic [5:0] ex;
    logic [3:0] m;
    logic       idle, keep, wdt;
    bit         ok;
    int         n, p, q;
    {rst_n_i, ext_reset_i, wdt_ovf_i, stack_full_i, hxt_sel_i, wdt_cfg_en} = '0;
    {wdt_src_sub_i, lvd_en_i, irq_en_i, seen, fail_count, checks} = '0;
    port_a_i = 8'hff;
    irq_req_i = 8'h01;
    rnd = 32'h18023e21;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    core.rd(`PMC_OFF_MODE, d);
    chk("mode reset", `PMC_RST_MODE, d & 8'hf3);
    core.rd(`PMC_OFF_WDOG, d);
    chk("wdog reset", `PMC_RST_WDOG, d);
    core.rd(`PMC_OFF_PAWAKE, d);
    chk("pawake reset", `PMC_RST_PAWAKE, d);
    core.wr(4'h2, 8'hff);
    core.rd(4'h2, d);
    chk("unmapped", 8'h00, d);
    core.wr(`PMC_OFF_STATUS, 8'h03);
    core.rd(`PMC_OFF_STATUS, d);
    chk("status flags", 8'h00, d & 8'h03);
    for (int k = 0; k < 8; k++) begin
      core.go_slow(k[0]);
      wait_st(pmc_pkg::PMC_SLOW, n);
      chk("slow wait", 8'h01, {7'h0, n >= 2});
      chk("slow state", {4'h0, pmc_pkg::PMC_SLOW}, {4'h0, st});
      chk("hosc off", 8'h00, {7'h0, clk_en.hosc});
      chk("sys low", 8'h01, {7'h0, clk_en.sys_low});
      core.go_fast(k[2:0], ok);
      chk("fast ready", 8'h01, {7'h0, ok});
      chk("fast state", {4'h0, pmc_pkg::PMC_NORMAL}, {4'h0, st});
    end
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      {wdt, keep, idle} = i[2:0];
      p = rnd[3:1];
      q = (p + 1) % 8;
      @(posedge clk_i);
      wdt_src_sub_i <= rnd[0];
      lvd_en_i <= keep & ~idle;
      irq_en_i <= rnd[23:16] | 8'h01;
      core.wr(`PMC_OFF_WDOG, {keep, 3'b111, wdt ? 4'h5 : `PMC_WDOG_OFF});
      core.wr(`PMC_OFF_MODE, {6'h00, idle, 1'b1});
      core.wr(`PMC_OFF_PAWAKE, (rnd[15:8] | 8'(1 << p)) & ~8'(1 << q));
      m = exp_mode(idle, keep, wdt, keep & ~idle);
      core.halt();
      #1 seen = evt;
      chk("halt state", {4'h0, m}, {4'h0, st});
      chk("halt clocks", {4'h0, exp_clk(m, wdt, rnd[0])},
          {4'h0, clk_en.sys, clk_en.time_base, clk_en.sub, clk_en.wdt_run});
      chk("halt wdt clear", 8'h01, {7'h0, seen[5]});
      core.rd(`PMC_OFF_STATUS, d);
      chk("halt flags", 8'h01, d & 8'h03);
      @(posedge clk_i);
      port_a_i[q] <= 1'b0;
      repeat (4) step();
      chk("no wake", {4'h0, m}, {4'h0, st});
      @(posedge clk_i);
      seen = '0;
      mk = 8'h1f;
      case (i % 4)
        0: begin port_a_i[p] <= 1'b0; ex = 6'b000101; end
        1: begin irq_en_i[4] <= 1'b1; irq_req_i[4] <= 1'b1; ex = 6'b000110; end
        2: begin stack_full_i <= 1'b1; irq_req_i[4] <= 1'b1; ex = 6'b000101; end
        default: begin ext_reset_i <= 1'b1; ex = 6'b010100; mk = 8'h1e; end
      endcase
      wait_st(pmc_pkg::PMC_NORMAL, n);
      chk("wake events", {2'b0, ex} & mk, {2'b0, seen} & mk);
      chk("wake return", {4'h0, pmc_pkg::PMC_NORMAL}, {4'h0, st});
      @(posedge clk_i);
      {ext_reset_i, stack_full_i, port_a_i, irq_req_i} <= {2'b00, 8'hff, 8'h01};
    end
    hxt_sel_i <= 1'b1;
    wdt_src_sub_i <= 1'b1;
    wdt_cfg_en <= 1'b1;
    // watchdog on through the config option, register code left at off
    core.wr(`PMC_OFF_WDOG, `PMC_RST_WDOG);
    core.wr(`PMC_OFF_MODE, 8'h11);
    core.halt();
    @(posedge clk_i);
    port_a_i[p] <= 1'b0;
    wait_st(pmc_pkg::PMC_FASTWAKE, n);
    chk("fast wake low", 8'h01, {7'h0, clk_en.sys_low});
    wait_st(pmc_pkg::PMC_NORMAL, n);
    chk("fast wake span", 8'h01, {7'h0, n >= HW - 2});
    chk("fast wake end", {4'h0, pmc_pkg::PMC_NORMAL}, {4'h0, st});
    @(posedge clk_i);
    port_a_i <= 8'hff;
    core.wr(`PMC_OFF_MODE, 8'h01);
    core.halt();
    @(posedge clk_i);
    seen = '0;
    wdt_ovf_i <= 1'b1;
    @(posedge clk_i);
    wdt_ovf_i <= 1'b0;
    #1 seen = evt;
    wait_st(pmc_pkg::PMC_NORMAL, n);
    chk("ovf events", 8'h0c, {2'b0, seen} & 8'h1e);
    core.rd(`PMC_OFF_STATUS, d);
    chk("ovf flags", 8'h03, d & 8'h03);
    core.clear();
    core.rd(`PMC_OFF_STATUS, d);
    chk("clear flags", 8'h02, d & 8'h03);
    end_sim();
  end
endmodule : testbench
